// file: inc/wkd_pkg.sv
// Package: constants and types of the wake input detector
package wkd_pkg;

  // ----------------------------------------------------------------
  // Clock and filter timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS     = 100;
  localparam int SHORT_FILTER_NS   = 16000;
  localparam int LONG_FILTER_NS    = 64000;
  localparam int SHORT_FILTER_CYC  = (SHORT_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LONG_FILTER_CYC   = (LONG_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FILT_CNT_W        = 10;

  // ----------------------------------------------------------------
  // Register map (word offsets on the plain port)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_WAKE_ENABLE_CTRL  = 4'h0;
  localparam logic [3:0] ADDR_WAKE_FILTER_CTRL  = 4'h1;
  localparam logic [3:0] ADDR_WAKE_BIAS_CTRL    = 4'h2;
  localparam logic [3:0] ADDR_WAKE_SOURCE_STAT  = 4'h3;
  localparam logic [3:0] ADDR_ALT_WAKE_STAT     = 4'h4;
  localparam logic [3:0] ADDR_WAKE_LEVEL_STAT   = 4'h5;
  localparam logic [3:0] ADDR_ALT_PIN_CTRL      = 4'h6;
  localparam logic [3:0] ADDR_IRQ_MASK          = 4'h7;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [2:0] RST_WAKE_ENABLE  = 3'h0;
  localparam logic [5:0] RST_FILTER_CTRL  = 6'h00;
  localparam logic [5:0] RST_BIAS_CTRL    = 6'h00;
  localparam logic [1:0] RST_ALT_PIN_CTRL = 2'h0;
  localparam logic [2:0] RST_IRQ_MASK     = 3'h0;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    WKD_FLT_STATIC_SHORT = 2'b00,
    WKD_FLT_STATIC_LONG  = 2'b01,
    WKD_FLT_CYCLIC_ONE   = 2'b10,
    WKD_FLT_CYCLIC_TWO   = 2'b11
  } wkd_filter_t;

  typedef enum logic [1:0] {
    WKD_BIAS_NONE = 2'b00,
    WKD_BIAS_DOWN = 2'b01,
    WKD_BIAS_UP   = 2'b10,
    WKD_BIAS_AUTO = 2'b11
  } wkd_bias_t;

  typedef enum logic [1:0] {
    WKD_MODE_NORMAL    = 2'b00,
    WKD_MODE_STOP      = 2'b01,
    WKD_MODE_SLEEP     = 2'b10,
    WKD_MODE_FAIL_SAFE = 2'b11
  } wkd_mode_t;

endpackage

// file: logic/wkd_filter.sv
// Module: one synchronised, deglitched edge detector for a wake input
`timescale 1ns/10ps
module wkd_filter
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       pin_i,
  input  wire logic       long_sel_i,
  input  wire logic       window_i,
  output logic            level_o,
  output logic            edge_o
);

  logic                        sync_a;
  logic                        sync_b;
  logic                        stable;
  logic [wkd_pkg::FILT_CNT_W-1:0] cnt;
  logic                        busy;
  logic [wkd_pkg::FILT_CNT_W-1:0] limit;

  // ----------------------------------------------------------------
  // Synchroniser
  // ----------------------------------------------------------------
  // Two flops from the comparator into the oscillator domain
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end
    else
    begin
      sync_a <= pin_i;
      sync_b <= sync_a;
    end
  end

  // Filter length by selection
  assign limit = long_sel_i ? wkd_pkg::FILT_CNT_W'(wkd_pkg::LONG_FILTER_CYC)
                            : wkd_pkg::FILT_CNT_W'(wkd_pkg::SHORT_FILTER_CYC);

  // ----------------------------------------------------------------
  // Deglitch filter
  // ----------------------------------------------------------------
  // Restart on every crossing; accept the edge when the count expires
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stable <= 1'b0;
      cnt    <= '0;
      busy   <= 1'b0;
      edge_o <= 1'b0;
    end
    else
    begin
      edge_o <= 1'b0;
      if (!window_i)
      begin
        busy <= 1'b0;
        cnt  <= '0;
      end
      else if (sync_b == stable)
      begin
        busy <= 1'b0;
        cnt  <= '0;
      end
      else if (!busy)
      begin
        busy <= 1'b1;
        cnt  <= wkd_pkg::FILT_CNT_W'(1);
      end
      else if (cnt >= limit - wkd_pkg::FILT_CNT_W'(1))
      begin
        stable <= sync_b;
        edge_o <= 1'b1;
        busy   <= 1'b0;
        cnt    <= '0;
      end
      else
      begin
        cnt <= cnt + wkd_pkg::FILT_CNT_W'(1);
      end
    end
  end

  assign level_o = stable;

  // Edge only after a full stable filter interval
  edge_filter_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    edge_o |-> $past(busy) && (stable != $past(stable)))
    else $error("edge without filtered level change");

endmodule

// file: logic/wkd_top.sv
// Module: wake input detector with register port and interrupt
//
// Implementation choices: the register addresses and the strobed register port.
`timescale 1ns/10ps
// What this block does
// - Three independent wake inputs, each a thresholded digital level.
// - Rising and falling filtered transitions both signal a wake.
// - Edge raises interrupt in normal or stop, wake-up in sleep or fail-safe.
// - Per-input static sense or cyclic sense within an active window.
// - Static sense selects a 16 us or 64 us deglitch filter.
// - Filter restarts at each crossing; early recrossing discards the event.
// - Per-pin wake enable; a disabled pin never causes wake-up.
// - Per-pin latched wake-source flag readable in any mode.
// - Live level readable in normal and stop, enabled or not.
// - In cyclic sense the level bit shows the last window sample.
// - Alternate output pins as wake inputs use static 16 us, own status.
// - Filter field: 00 s16, 01 s64, 10 cyclic one, 11 cyclic two.
// - Bias field: none, pull-down, pull-up, automatic by detected level.
module wkd_top
(
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [2:0] hv_input_i,
  input  wire logic [1:0] alt_fail_output_pins_i,
  input  wire logic       cyclic_timer_one_i,
  input  wire logic       cyclic_timer_two_i,
  input  wire logic [1:0] op_mode_i,
  input  wire logic [3:0] addr_i,
  input  wire logic [7:0] wdata_i,
  input  wire logic       wr_i,
  input  wire logic       rd_i,
  output logic      [7:0] rdata_o,
  output logic      [2:0] pull_up_en_o,
  output logic      [2:0] pull_down_en_o,
  output logic            wake_up_o,
  output logic            irq_o
);

  logic [2:0] wake_enable_ctrl;
  logic [5:0] wake_filter_ctrl;
  logic [5:0] wake_bias_ctrl;
  logic [1:0] alt_pin_ctrl;
  logic [2:0] irq_mask;
  logic [2:0] wake_source_status;
  logic [1:0] alt_wake_source_status;
  logic [4:0] wake_level_status;
  logic [2:0] irq_status;
  logic [2:0] pin_level;
  logic [2:0] pin_edge;
  logic [2:0] pin_window;
  logic [2:0] pin_long;
  logic [2:0] pin_cyclic;
  logic [1:0] alt_level;
  logic [1:0] alt_edge;
  logic       low_power;
  logic       pin1_woke_flag;
  logic       pin2_woke_flag;
  logic       pin3_woke_flag;
  logic [2:0] wake_event;
  logic [2:0] int_event;

  // ----------------------------------------------------------------
  // Per-pin filter configuration
  // ----------------------------------------------------------------
  // Decode filter field into window and filter length
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      unique case (wkd_pkg::wkd_filter_t'(wake_filter_ctrl[2*i +: 2]))
        wkd_pkg::WKD_FLT_STATIC_SHORT:
        begin
          pin_window[i] = 1'b1;
          pin_long[i]   = 1'b0;
          pin_cyclic[i] = 1'b0;
        end
        wkd_pkg::WKD_FLT_STATIC_LONG:
        begin
          pin_window[i] = 1'b1;
          pin_long[i]   = 1'b1;
          pin_cyclic[i] = 1'b0;
        end
        wkd_pkg::WKD_FLT_CYCLIC_ONE:
        begin
          pin_window[i] = cyclic_timer_one_i;
          pin_long[i]   = 1'b0;
          pin_cyclic[i] = 1'b1;
        end
        wkd_pkg::WKD_FLT_CYCLIC_TWO:
        begin
          pin_window[i] = cyclic_timer_two_i;
          pin_long[i]   = 1'b0;
          pin_cyclic[i] = 1'b1;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Filters
  // ----------------------------------------------------------------
  // One filter for each high-voltage wake input
  for (genvar g = 0; g < 3; g++)
  begin : g_hv
    wkd_filter u_filt
    (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .pin_i      (hv_input_i[g]),
      .long_sel_i (pin_long[g]),
      .window_i   (pin_window[g]),
      .level_o    (pin_level[g]),
      .edge_o     (pin_edge[g])
    );
  end

  // Alternate pins: static sense, fixed short filter
  for (genvar g = 0; g < 2; g++)
  begin : g_alt
    wkd_filter u_filt
    (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .pin_i      (alt_fail_output_pins_i[g]),
      .long_sel_i (1'b0),
      .window_i   (alt_pin_ctrl[g]),
      .level_o    (alt_level[g]),
      .edge_o     (alt_edge[g])
    );
  end

  // ----------------------------------------------------------------
  // Event routing
  // ----------------------------------------------------------------
  // Sleep and fail-safe wake, normal and stop interrupt
  assign low_power  = (op_mode_i == wkd_pkg::WKD_MODE_SLEEP) ||
                      (op_mode_i == wkd_pkg::WKD_MODE_FAIL_SAFE);
  assign wake_event = pin_edge & wake_enable_ctrl & {3{low_power}};
  assign int_event  = pin_edge & {3{~low_power}};

  // Wake-up pulse towards the power manager
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wake_up_o <= 1'b0;
    else
      wake_up_o <= |wake_event;
  end

  // ----------------------------------------------------------------
  // Bias control
  // ----------------------------------------------------------------
  // Pull sources; automatic follows the detected level
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      unique case (wkd_pkg::wkd_bias_t'(wake_bias_ctrl[2*i +: 2]))
        wkd_pkg::WKD_BIAS_NONE:
        begin
          pull_up_en_o[i]   = 1'b0;
          pull_down_en_o[i] = 1'b0;
        end
        wkd_pkg::WKD_BIAS_DOWN:
        begin
          pull_up_en_o[i]   = 1'b0;
          pull_down_en_o[i] = 1'b1;
        end
        wkd_pkg::WKD_BIAS_UP:
        begin
          pull_up_en_o[i]   = 1'b1;
          pull_down_en_o[i] = 1'b0;
        end
        wkd_pkg::WKD_BIAS_AUTO:
        begin
          pull_up_en_o[i]   = pin_level[i];
          pull_down_en_o[i] = ~pin_level[i];
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Software-written configuration
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wake_enable_ctrl <= wkd_pkg::RST_WAKE_ENABLE;
      wake_filter_ctrl <= wkd_pkg::RST_FILTER_CTRL;
      wake_bias_ctrl   <= wkd_pkg::RST_BIAS_CTRL;
      alt_pin_ctrl     <= wkd_pkg::RST_ALT_PIN_CTRL;
      irq_mask         <= wkd_pkg::RST_IRQ_MASK;
    end
    else if (wr_i)
    begin
      unique case (addr_i)
        wkd_pkg::ADDR_WAKE_ENABLE_CTRL: wake_enable_ctrl <= wdata_i[2:0];
        wkd_pkg::ADDR_WAKE_FILTER_CTRL: wake_filter_ctrl <= wdata_i[5:0];
        wkd_pkg::ADDR_WAKE_BIAS_CTRL:   wake_bias_ctrl   <= wdata_i[5:0];
        wkd_pkg::ADDR_ALT_PIN_CTRL:     alt_pin_ctrl     <= wdata_i[1:0];
        wkd_pkg::ADDR_IRQ_MASK:         irq_mask         <= wdata_i[2:0];
        default:                        irq_mask         <= irq_mask;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Status registers
  // ----------------------------------------------------------------
  // Sticky flags, cleared by read, set wins
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wake_source_status     <= 3'h0;
      alt_wake_source_status <= 2'h0;
      irq_status             <= 3'h0;
    end
    else
    begin
      wake_source_status <= ((rd_i && addr_i == wkd_pkg::ADDR_WAKE_SOURCE_STAT) ?
                             3'h0 : wake_source_status) | wake_event;
      alt_wake_source_status <= ((rd_i && addr_i == wkd_pkg::ADDR_ALT_WAKE_STAT) ?
                                 2'h0 : alt_wake_source_status) | alt_edge;
      irq_status <= ((rd_i && addr_i == wkd_pkg::ADDR_IRQ_MASK) ?
                     3'h0 : irq_status) | int_event;
    end
  end

  assign pin1_woke_flag = wake_source_status[0];
  assign pin2_woke_flag = wake_source_status[1];
  assign pin3_woke_flag = wake_source_status[2];

  // Level status: live when static, window sample when cyclic
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      wake_level_status <= 5'h00;
    else if (!low_power)
    begin
      for (int i = 0; i < 3; i++)
      begin
        if (!pin_cyclic[i] || pin_window[i])
          wake_level_status[i] <= pin_level[i];
      end
      wake_level_status[4:3] <= alt_level;
    end
  end

  // Interrupt output, high while an unmasked flag stands
  assign irq_o = |(irq_status & irq_mask);

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= 8'h00;
    else if (!rd_i)
      rdata_o <= 8'h00;
    else
    begin
      unique case (addr_i)
        wkd_pkg::ADDR_WAKE_ENABLE_CTRL: rdata_o <= {5'h00, wake_enable_ctrl};
        wkd_pkg::ADDR_WAKE_FILTER_CTRL: rdata_o <= {2'h0, wake_filter_ctrl};
        wkd_pkg::ADDR_WAKE_BIAS_CTRL:   rdata_o <= {2'h0, wake_bias_ctrl};
        wkd_pkg::ADDR_WAKE_SOURCE_STAT:
          rdata_o <= {5'h00, pin3_woke_flag, pin2_woke_flag, pin1_woke_flag};
        wkd_pkg::ADDR_ALT_WAKE_STAT:    rdata_o <= {6'h00, alt_wake_source_status};
        wkd_pkg::ADDR_WAKE_LEVEL_STAT:  rdata_o <= {3'h0, wake_level_status};
        wkd_pkg::ADDR_ALT_PIN_CTRL:     rdata_o <= {6'h00, alt_pin_ctrl};
        wkd_pkg::ADDR_IRQ_MASK:         rdata_o <= {2'h0, irq_status, irq_mask};
        default:                        rdata_o <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  disabled_no_wake_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wake_up_o |-> |($past(pin_edge) & $past(wake_enable_ctrl)))
    else $error("wake from disabled pin");

  wake_in_sleep_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (|(pin_edge & wake_enable_ctrl) && low_power) |=> wake_up_o)
    else $error("enabled edge in sleep gave no wake");

  no_wake_active_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    !low_power |=> !wake_up_o || $past(low_power, 1) == 1'b1)
    else $error("wake pulse outside low power");

  flag_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    wake_event[0] |=> pin1_woke_flag)
    else $error("wake flag not set");

  irq_set_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (int_event[1] && irq_mask[1] && !wr_i) |=> irq_o)
    else $error("interrupt not raised");

  static_level_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (!low_power && !pin_cyclic[2]) |=> wake_level_status[2] == $past(pin_level[2]))
    else $error("level status not live");

  cyclic_hold_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (pin_cyclic[0] && !pin_window[0]) |=> $stable(wake_level_status[0]))
    else $error("cyclic level changed outside window");

  auto_bias_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
    (wake_bias_ctrl[1:0] == 2'b11) |-> pull_up_en_o[0] == pin_level[0]
                                       && pull_down_en_o[0] == !pin_level[0])
    else $error("automatic bias wrong");

endmodule

// file: test/wake_input_detector_bench.sv
// Testbench: register, interrupt and wake checks of the wake input detector
`timescale 1ns/10ps
module wake_input_detector_bench;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [2:0] hv_input;
  logic [1:0] alt_pins;
  logic       win_one = 1'b0;
  logic       win_two = 1'b0;
  logic [1:0] op_mode = 2'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic [7:0] rdata;
  logic [2:0] pull_up_en;
  logic [2:0] pull_down_en;
  logic       wake_up;
  logic       irq;
  logic [7:0] rval;
  int         fails = 0;
  int         samples_checked = 0;
  int         wake_cnt = 0;
  logic [3:0] rw_addr [6] = '{4'h0, 4'h1, 4'h2, 4'h6, 4'h7, 4'h3};
  logic [7:0] rw_exp [6] = '{8'h07, 8'h3F, 8'h3F, 8'h03, 8'h07, 8'h00};
  logic [7:0] bias_exp [4] = '{8'h00, 8'h01, 8'h02, 8'h01};

  wkd_top i_wkd_top
  (
    .core_clk_i             (core_clk),
    .rst_n_i                (rst_n),
    .hv_input_i             (hv_input),
    .alt_fail_output_pins_i (alt_pins),
    .cyclic_timer_one_i     (win_one),
    .cyclic_timer_two_i     (win_two),
    .op_mode_i              (op_mode),
    .addr_i                 (addr),
    .wdata_i                (wdata),
    .wr_i                   (wr),
    .rd_i                   (rd),
    .rdata_o                (rdata),
    .pull_up_en_o           (pull_up_en),
    .pull_down_en_o         (pull_down_en),
    .wake_up_o              (wake_up),
    .irq_o                  (irq)
  );

  wkd_switch_model i_wkd_switch_model
  (
    .core_clk_i     (core_clk),
    .pull_up_en_i   (pull_up_en),
    .pull_down_en_i (pull_down_en),
    .hv_input_o     (hv_input),
    .alt_pins_o     (alt_pins)
  );

  // 10 MHz clock
  always #50 core_clk = ~core_clk;

  // Counts wake-up pulses
  always @(posedge core_clk)
    if (wake_up === 1'b1)
      wake_cnt <= wake_cnt + 1;

  // ----------------------------------------------------------------
  // Access and compare tasks
  // ----------------------------------------------------------------
  task check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("unexpected at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task test_done();
    $display("compares %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task reg_wr(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task reg_rd(input logic [3:0] a, output logic [7:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    d = rdata;
    @(posedge core_clk);
  endtask

  task rd_chk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    reg_rd(a, d);
    check(d, exp);
  endtask

  // Bounded wait for the interrupt line
  task wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
    check({7'h00, irq}, 8'h01);
    if (irq !== 1'b1)
      test_done();
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    tick(6);
    rst_n <= 1'b1;
    tick(1);
    for (int a = 0; a < 10; a++)
      rd_chk(a[3:0], 8'h00);
    for (int k = 0; k < 6; k++)
    begin
      reg_wr(rw_addr[k], 8'hFF);
      rd_chk(rw_addr[k], rw_exp[k]);
      reg_wr(rw_addr[k], 8'h00);
    end
    // Rising edge, unmasked, in normal mode
    reg_wr(4'h7, 8'h01);
    i_wkd_switch_model.set_pin(0, 1'b1);
    tick(150);
    check({7'h00, irq}, 8'h00);
    wait_irq(40);
    rd_chk(4'h7, 8'h09);
    check({7'h00, irq}, 8'h00);
    rd_chk(4'h5, 8'h01);
    // Falling edge, masked
    reg_wr(4'h7, 8'h00);
    i_wkd_switch_model.set_pin(0, 1'b0);
    tick(200);
    check({7'h00, irq}, 8'h00);
    rd_chk(4'h7, 8'h08);
    // Short pulse is discarded, then the long filter
    reg_wr(4'h7, 8'h07);
    i_wkd_switch_model.set_pin(1, 1'b1);
    tick(100);
    i_wkd_switch_model.set_pin(1, 1'b0);
    tick(250);
    rd_chk(4'h7, 8'h07);
    reg_wr(4'h1, 8'h04);
    i_wkd_switch_model.set_pin(1, 1'b1);
    tick(600);
    check({7'h00, irq}, 8'h00);
    wait_irq(80);
    rd_chk(4'h7, 8'h17);
    // Stop mode still interrupts
    op_mode <= wkd_pkg::WKD_MODE_STOP;
    i_wkd_switch_model.set_pin(2, 1'b1);
    wait_irq(200);
    rd_chk(4'h7, 8'h27);
    // Sleep and fail-safe wake only through enabled pins
    op_mode <= wkd_pkg::WKD_MODE_SLEEP;
    reg_wr(4'h0, 8'h04);
    i_wkd_switch_model.set_pin(1, 1'b0);
    tick(700);
    i_wkd_switch_model.set_pin(2, 1'b0);
    tick(200);
    check(wake_cnt[7:0], 8'h01);
    check({7'h00, irq}, 8'h00);
    rd_chk(4'h3, 8'h04);
    rd_chk(4'h3, 8'h00);
    op_mode <= wkd_pkg::WKD_MODE_FAIL_SAFE;
    i_wkd_switch_model.set_pin(2, 1'b1);
    tick(200);
    check(wake_cnt[7:0], 8'h02);
    rd_chk(4'h3, 8'h04);
    op_mode <= wkd_pkg::WKD_MODE_NORMAL;
    tick(4);
    rd_chk(4'h5, 8'h04);
    // Every bias code on pin one, then automatic switching
    for (int b = 0; b < 4; b++)
    begin
      reg_wr(4'h2, b[7:0]);
      tick(1);
      check({6'h00, pull_up_en[0], pull_down_en[0]}, bias_exp[b]);
    end
    i_wkd_switch_model.free_pin(0);
    tick(200);
    check({6'h00, pull_up_en[0], pull_down_en[0]}, 8'h01);
    i_wkd_switch_model.set_pin(0, 1'b1);
    tick(200);
    i_wkd_switch_model.free_pin(0);
    tick(200);
    check({6'h00, pull_up_en[0], pull_down_en[0]}, 8'h02);
    rd_chk(4'h5, 8'h05);
    rd_chk(4'h7, 8'h0F);
    // Alternate pins flag in their own register, no interrupt
    reg_wr(4'h6, 8'h01);
    i_wkd_switch_model.set_alt(0, 1'b1);
    i_wkd_switch_model.set_alt(1, 1'b1);
    tick(200);
    rd_chk(4'h4, 8'h01);
    check({7'h00, irq}, 8'h00);
    // Cyclic sense on pin three with each timer
    for (int t = 0; t < 2; t++)
    begin
      reg_wr(4'h1, t[0] ? 8'h30 : 8'h20);
      i_wkd_switch_model.set_pin(2, t[0]);
      tick(300);
      check({7'h00, irq}, 8'h00);
      reg_rd(4'h5, rval);
      check({6'h00, rval[4:3]}, 8'h01);
      check({7'h00, rval[2]}, {7'h00, ~t[0]});
      if (t == 0)
        win_one <= 1'b1;
      else
        win_two <= 1'b1;
      tick(200);
      win_one <= 1'b0;
      win_two <= 1'b0;
      reg_rd(4'h5, rval);
      check({7'h00, rval[2]}, {7'h00, t[0]});
      rd_chk(4'h7, 8'h27);
    end
    // Mid-run reset returns configuration, flags and levels to zero
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(1);
    rd_chk(4'h1, 8'h00);
    rd_chk(4'h5, 8'h00);
    rd_chk(4'h7, 8'h00);
    test_done();
  end
endmodule

// file: test/wkd_switch_model.sv
// Behavioural model of the switches and sensors on the wake pins
`timescale 1ns/10ps
module wkd_switch_model
(
  input  wire logic       core_clk_i,
  input  wire logic [2:0] pull_up_en_i,
  input  wire logic [2:0] pull_down_en_i,
  output logic      [2:0] hv_input_o,
  output logic      [1:0] alt_pins_o
);
  logic [2:0] closed;
  logic [2:0] level;

  // Switches start closed to ground, so every pin begins low
  initial
  begin
    closed = 3'h7;
    level = 3'h0;
    hv_input_o = 3'h0;
    alt_pins_o = 2'h0;
  end

  // Closed switch drives the pin; an open pin follows its current source
  always @(posedge core_clk_i)
  begin
    for (int k = 0; k < 3; k++)
    begin
      if (closed[k])
        hv_input_o[k] <= level[k];
      else if (pull_up_en_i[k])
        hv_input_o[k] <= 1'b1;
      else if (pull_down_en_i[k])
        hv_input_o[k] <= 1'b0;
      else
        hv_input_o[k] <= ~hv_input_o[k]; // Floating pin never settles
    end
  end

  // Close a switch to a level, or open it
  task set_pin(input int k, input logic v);
    closed[k] <= 1'b1;
    level[k] <= v;
  endtask

  task free_pin(input int k);
    closed[k] <= 1'b0;
  endtask

  task set_alt(input int k, input logic v);
    alt_pins_o[k] <= v;
  endtask
endmodule
